// [logic/svmd_pkg.sv]
// svmd_pkg: constants, encodings and issue carriers of the math datapath
// assumes one core clock and an APB master for the three control words
package svmd_pkg;
  localparam logic [7:0]  ADDR_MODE     = 8'h00;
  localparam logic [7:0]  ADDR_SHIFT    = 8'h04;
  localparam logic [7:0]  ADDR_STAT     = 8'h08;
  localparam int          MODE_RND_LSB  = 0;
  localparam int          MODE_SAT_BIT  = 3;
  localparam int          MODE_OW_LSB   = 4;
  localparam int          MODE_W80_BIT  = 6;
  localparam int          SHIFT_ILV_BIT = 7;
  localparam int          STAT_SAT_BIT  = 0;
  localparam logic [6:0]  MODE_RST      = 7'h00;
  localparam logic [7:0]  SHIFT_RST     = 8'h00;
  localparam int          LAT_LONG      = 4;
  localparam int          LAT_FMUL      = 3;
  localparam int          STORE_STAGES  = 4;
  localparam int          SIN_ANG_LSB   = 12;
  localparam logic [15:0] COS_PHASE     = 16'h4000;
  localparam logic [31:0] F_ONE         = 32'h3f800000;
  localparam logic [31:0] SQRT_K        = 32'h1fc00000;
  localparam logic [31:0] RSQRT_K       = 32'h5f3759df;
  localparam logic [31:0] RECIP_K       = 32'h7ef311c3;

  typedef enum logic [2:0] {
    RND_TRUNC = 3'b000, RND_CEIL = 3'b001, RND_TOWARD_POSITIVE = 3'b010,
    RND_TOWARD_NEGATIVE = 3'b011, RND_HALF_AWAY = 3'b100,
    RND_HALF_TOWARD_ORIGIN = 3'b101, RND_HALF_TO_EVEN = 3'b110, RND_HALF_TO_ODD = 3'b111
  } svmd_rnd_t;

  typedef enum logic [3:0] {
    SC_SINCOS = 4'h0, SC_MAG = 4'h1, SC_LZC = 4'h2, SC_MIN = 4'h3, SC_MAX = 4'h4,
    SC_FSQRT = 4'h5, SC_FRSQRT = 4'h6, SC_FRECIP = 4'h7, SC_FMAG = 4'h8,
    SC_FMIN = 4'h9, SC_FMAX = 4'ha, SC_I2F = 4'hb, SC_F2I = 4'hc
  } svmd_sop_t;

  typedef enum logic [2:0] {
    V_NOP = 3'b000, V_MAC = 3'b001, V_UPS = 3'b010, V_SRS = 3'b011, V_FMUL = 3'b100
  } svmd_vop_t;

  typedef struct packed {
    logic        valid;
    svmd_sop_t   op;
    logic [31:0] a;
    logic [31:0] b;
  } svmd_sreq_t;

  typedef struct packed {
    logic       valid;
    svmd_vop_t  op;
    logic [3:0] lRot;
    logic [3:0] rRot;
    logic [3:0] cRot;
    logic       preSub;
    logic       swap;
    logic [1:0] cond;
    logic       reduce2;
    logic       dst;
    logic [1:0] addSel;
    logic       accSub;
    logic       upsVec;
    logic [4:0] upsAmt;
    logic       toMem;
    logic [7:0] fNeg;
    logic       fOne;
  } svmd_vreq_t;
endpackage

// [logic/svmd_top.sv]
// svmd_top: scalar elementary functions, fixed-point vector MAC, upshift and
// narrowing paths, eight-lane float multiply stage, APB control words.
// assumes operands come already read from the register files and that the
// issuer keeps to one vector request per cycle.
//
// What this block does
// - sine/cosine angle is top 20 source bits
// - sine high, cosine low, four cycles
// - magnitude, leading zeros, min/max: one cycle
// - roots and reciprocal float only, four cycles
// - float roots four cycles, magnitude/minmax one
// - conversions scale by binary point, one cycle
// - permute, pre-add, multiply, post-add, accumulate
// - upshift runs beside multiply into accumulators
// - narrowing shifts each 48/80-bit lane
// - rounding codes zero through seven
// - saturation/rounding from mode, outcome in status
// - three permuters feed the multiplier
// - pre-combiner adds or subtracts permuted operands
// - conditioner gives constant one or sign extension
// - reducers take 32 lanes to 16, 8
// - addend selector, then add or subtract
// - narrowed result to vector or memory E6
// - lane merger joins 80-bit halves
// - shift MSB interleaves low and high halves
// - one vector request per cycle, shared permuters
// - eight float products, three-cycle pipeline
// - per-lane sign negation after float multiply
// - accumulators are sixteen 48-bit lanes
module svmd_top (
  // clock and reset
  input  logic                   clk,
  input  logic                   rst,
  // apb slave
  input  logic                   psel,
  input  logic                   penable,
  input  logic                   pwrite,
  input  logic [7:0]             paddr,
  input  logic [31:0]            pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // scalar issue and results
  input  svmd_pkg::svmd_sreq_t   sReq,
  output logic                   sShortValid,
  output logic [31:0]            sShortData,
  output logic                   sLongValid,
  output logic [31:0]            sLongData,
  // vector issue and sources
  input  svmd_pkg::svmd_vreq_t   vReq,
  input  logic [511:0]           srcL,
  input  logic [511:0]           srcR,
  input  logic [511:0]           srcC,
  input  logic [383:0]           cascadeIn,
  // vector results
  output logic [767:0]           accOut,
  output logic                   vecValid,
  output logic [1023:0]          vecData,
  output logic                   memValid,
  output logic [1023:0]          memData,
  output logic                   fValid,
  output logic [255:0]           fData
);
  import svmd_pkg::*;

  logic [6:0]  mode_r;
  logic [7:0]  shift_r;
  logic        satSticky_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        srsSat_r;

  wire        apbAcc   = psel && penable;
  wire        apbWr    = apbAcc && pready_r && pwrite;
  wire        hitMode  = paddr == ADDR_MODE;
  wire        hitShift = paddr == ADDR_SHIFT;
  wire        hitStat  = paddr == ADDR_STAT;
  wire [31:0] rdMux    = hitMode ? {25'h0, mode_r} : hitShift ? {24'h0, shift_r} :
                         hitStat ? {31'h0, satSticky_r} : 32'h0;
  wire        statClr  = apbWr && hitStat && pwdata[STAT_SAT_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apbAcc && !pready_r;
      if (apbAcc && !pready_r) begin
        prdata_r  <= rdMux;
        pslverr_r <= !(hitMode || hitShift || hitStat);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r      <= MODE_RST;
      shift_r     <= SHIFT_RST;
      satSticky_r <= 1'b0;
    end else begin
      if (apbWr && hitMode) mode_r <= pwdata[6:0];
      if (apbWr && hitShift) shift_r <= pwdata[7:0];
      // a saturation in the clearing cycle keeps the flag set
      satSticky_r <= srsSat_r || (satSticky_r && !statClr);
    end
  end

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // scalar unit
  function automatic logic [5:0] lzc(input logic [31:0] v);
    lzc = 6'd32;
    for (int i = 0; i < 32; i++) if (v[i]) lzc = 6'(31 - i);
  endfunction

  // parabolic sine of pi*u, u in Q15; coarse but cheap
  function automatic logic [15:0] sinq(input logic [15:0] u);
    logic [15:0]        au;
    logic [16:0]        om;
    logic signed [33:0] q;
    au = u[15] ? 16'(-u) : u;
    om = 17'h08000 - {1'b0, au};
    q  = 34'($signed(u) * $signed({1'b0, om})) >>> 13;
    if (q > 34'sh07fff) sinq = 16'h7fff;
    else if (q < -34'sh08000) sinq = 16'h8000;
    else sinq = q[15:0];
  endfunction

  function automatic logic [31:0] fkey(input logic [31:0] x);
    fkey = x[31] ? ~x : {1'b1, x[30:0]};
  endfunction

  function automatic logic [31:0] i2f(input logic [31:0] a, input logic [7:0] bp);
    logic [31:0]       m;
    logic [31:0]       n;
    logic [5:0]        z;
    logic signed [9:0] e;
    m = a[31] ? 32'(-a) : a;
    z = lzc(m);
    n = m << z;
    e = 10'sd158 - $signed({4'h0, z}) - $signed({{2{bp[7]}}, bp});
    if (m == 32'h0 || e <= 0) i2f = {a[31], 31'h0};
    else if (e >= 10'sd255) i2f = {a[31], 8'hff, 23'h0};
    else i2f = {a[31], e[7:0], n[30:8]};
  endfunction

  function automatic logic [31:0] f2i(input logic [31:0] a, input logic [7:0] bp);
    logic signed [9:0] e;
    logic [54:0]       t;
    e = $signed({2'b00, a[30:23]}) - 10'sd127 + $signed({{2{bp[7]}}, bp});
    t = 55'({1'b1, a[22:0]}) << e[4:0];
    if (a[30:23] == 8'h00 || e < 0) f2i = 32'h0;
    else if (e > 10'sd30) f2i = a[31] ? 32'h80000000 : 32'h7fffffff;
    else f2i = a[31] ? 32'(-t[54:23]) : t[54:23];
  endfunction

  wire [19:0] ang    = sReq.a[31:SIN_ANG_LSB];
  wire [15:0] angQ   = ang[19:4];
  wire        isLong = sReq.op inside {SC_SINCOS, SC_FSQRT, SC_FRSQRT, SC_FRECIP};
  logic [31:0] shortRes;
  logic [31:0] longRes;
  logic [31:0] lp_r [LAT_LONG];
  logic        lv_r [LAT_LONG];

  always_comb begin
    shortRes = 32'h0;
    longRes  = 32'h0;
    case (sReq.op)
      SC_SINCOS: longRes  = {sinq(angQ), sinq(angQ + COS_PHASE)};
      SC_MAG:    shortRes = sReq.a[31] ? 32'(~sReq.a + 32'h1) : sReq.a;
      SC_LZC:    shortRes = {26'h0, lzc(sReq.a)};
      SC_MIN:    shortRes = $signed(sReq.a) < $signed(sReq.b) ? sReq.a : sReq.b;
      SC_MAX:    shortRes = $signed(sReq.a) > $signed(sReq.b) ? sReq.a : sReq.b;
      SC_FSQRT:  longRes  = (sReq.a >> 1) + SQRT_K;
      SC_FRSQRT: longRes  = RSQRT_K - (sReq.a >> 1);
      SC_FRECIP: longRes  = RECIP_K - sReq.a;
      SC_FMAG:   shortRes = {1'b0, sReq.a[30:0]};
      SC_FMIN:   shortRes = fkey(sReq.a) < fkey(sReq.b) ? sReq.a : sReq.b;
      SC_FMAX:   shortRes = fkey(sReq.a) > fkey(sReq.b) ? sReq.a : sReq.b;
      SC_I2F:    shortRes = i2f(sReq.a, sReq.b[7:0]);
      SC_F2I:    shortRes = f2i(sReq.a, sReq.b[7:0]);
      default:   shortRes = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sShortValid <= 1'b0;
      sShortData  <= 32'h0;
    end else begin
      sShortValid <= sReq.valid && !isLong;
      sShortData  <= shortRes;
    end
  end

  // long ops run in a fixed pipe so a short op can issue right behind them
  for (genvar k = 0; k < LAT_LONG; k++) begin : g_lp
    always_ff @(posedge clk) begin
      if (rst) begin
        lv_r[k] <= 1'b0;
        lp_r[k] <= 32'h0;
      end else if (k == 0) begin
        lv_r[k] <= sReq.valid && isLong;
        lp_r[k] <= longRes;
      end else begin
        lv_r[k] <= lv_r[k-1];
        lp_r[k] <= lp_r[k-1];
      end
    end
  end
  assign sLongValid = lv_r[LAT_LONG-1];
  assign sLongData  = lp_r[LAT_LONG-1];

  // vector unit: one request port, so fixed and float issue never overlap
  function automatic logic [511:0] perm(input logic [511:0] s, input logic [3:0] r);
    logic [1023:0] d;
    d    = {s, s} >> (32 * r);
    perm = d[511:0];
  endfunction

  wire         vGo = vReq.valid;
  wire [511:0] pl  = perm(srcL, vReq.lRot);
  wire [511:0] pr  = perm(srcR, vReq.rRot);
  wire [511:0] pc  = perm(srcC, vReq.cRot);
  logic [511:0]       prs;
  logic signed [32:0] prod [32];
  logic signed [33:0] r1 [16];
  logic signed [34:0] r2 [8];
  logic [47:0]        acc_r [16];

  for (genvar j = 0; j < 32; j++) begin : g_mul
    wire signed [15:0] l  = pl[16*j +: 16];
    wire signed [15:0] r  = prs[16*j +: 16];
    wire signed [16:0] le = l;
    wire signed [16:0] re = r;
    wire signed [16:0] pre = vReq.preSub ? le - re : le + re;
    wire signed [15:0] y   = vReq.cond == 2'd0 ? r : vReq.cond == 2'd1 ? pc[16*j +: 16] :
                             vReq.cond == 2'd2 ? 16'sh0001 : {{8{r[7]}}, r[7:0]};
    assign prod[j] = pre * y;
  end
  // halves swap inside each 32-bit word covers the permuters' word granularity
  for (genvar w = 0; w < 16; w++) begin : g_swap
    assign prs[32*w +: 32] = vReq.swap ? {pr[32*w +: 16], pr[32*w+16 +: 16]} : pr[32*w +: 32];
  end
  for (genvar k = 0; k < 16; k++) begin : g_red1
    assign r1[k] = prod[2*k] + prod[2*k+1];
  end
  for (genvar m = 0; m < 8; m++) begin : g_red2
    assign r2[m] = r1[2*m] + r1[2*m+1];
  end

  // lanes 0..7 form the low accumulator, 8..15 the high one
  for (genvar n = 0; n < 16; n++) begin : g_acc
    localparam logic H = 1'(n / 8);
    wire signed [47:0] pass  = r1[n];
    wire signed [47:0] red   = (vReq.dst == H) ? 48'(r2[n%8]) : 48'sh0;
    wire signed [47:0] post  = vReq.reduce2 ? red : pass;
    wire signed [15:0] upSrc = vReq.upsVec ? srcL[16*n +: 16] : pl[16*n +: 16];
    wire        [47:0] left_shift_unit   = 48'(upSrc) << vReq.upsAmt;
    wire        [47:0] add   = vReq.addSel == 2'd0 ? acc_r[n] : vReq.addSel == 2'd1 ? left_shift_unit :
                               cascadeIn[48*(n%8) +: 48];
    wire        [47:0] sum   = vReq.accSub ? add - post : add + post;
    wire               wen   = !vReq.reduce2 || vReq.dst == H;
    always_ff @(posedge clk) begin
      if (rst) acc_r[n] <= 48'h0;
      else if (vGo && vReq.op == V_MAC && wen) acc_r[n] <= sum;
      else if (vGo && vReq.op == V_UPS) acc_r[n] <= left_shift_unit;
    end
    assign accOut[48*n +: 48] = acc_r[n];
  end

  // narrowing shifter
  wire        [5:0] shAmt = shift_r[5:0];
  wire              ilv   = shift_r[SHIFT_ILV_BIT];
  wire              w80   = mode_r[MODE_W80_BIT];
  wire              satEn = mode_r[MODE_SAT_BIT];
  wire        [1:0] ow    = mode_r[MODE_OW_LSB +: 2];
  wire        [6:0] wOut  = 7'd8 << ow;
  wire       [79:0] mask  = (80'h1 << shAmt) - 80'h1;
  svmd_rnd_t        rnd;
  logic      [63:0] res [16];
  logic      [15:0] satL;
  logic    [1023:0] packed_w;
  assign rnd = svmd_rnd_t'(mode_r[MODE_RND_LSB +: 3]);

  for (genvar j = 0; j < 16; j++) begin : g_srs
    logic signed [79:0] v80;
    logic               inc;
    if (j < 8) begin : g_m
      localparam int B = (j / 4) * 8 + 2 * (j % 4);
      assign v80 = {acc_r[B+1][31:0], acc_r[B]};
    end else begin : g_z
      assign v80 = 80'sh0;
    end
    wire signed [79:0] v    = w80 ? v80 : 80'($signed(acc_r[j]));
    wire signed [79:0] fl   = v >>> shAmt;
    wire               half = shAmt != 6'h0 && v[6'(shAmt - 6'h1)];
    wire               rest = (v & (mask >> 1)) != 80'h0;
    wire               any  = (v & mask) != 80'h0;
    always_comb begin
      case (rnd)
        RND_TRUNC:              inc = 1'b0;
        RND_CEIL:               inc = any;
        RND_TOWARD_POSITIVE:    inc = half;
        RND_TOWARD_NEGATIVE:    inc = half && rest;
        RND_HALF_AWAY:          inc = v[79] ? half && rest : half;
        RND_HALF_TOWARD_ORIGIN: inc = v[79] ? half : half && rest;
        RND_HALF_TO_EVEN:       inc = half && (rest || fl[0]);
        RND_HALF_TO_ODD:        inc = half && (rest || !fl[0]);
        default:                inc = 1'b0;
      endcase
    end
    wire signed [79:0] rv   = fl + {79'h0, inc};
    wire signed [79:0] hi   = rv >>> (wOut - 7'h1);
    wire               fits = hi == 80'sh0 || hi == -80'sh1;
    wire        [63:0] mx   = (64'h1 << (wOut - 7'h1)) - 64'h1;
    assign satL[j] = satEn && !fits;
    assign res[j]  = satL[j] ? (rv[79] ? ~mx : mx) : rv[63:0];
  end

  // output lanes packed at the chosen width; interleave alternates halves
  always_comb begin
    int nh;
    int p;
    packed_w = '0;
    nh = w80 ? 4 : 8;
    p = 0;
    for (int j = 0; j < 16; j++) begin
      p = ilv ? 2 * (j % nh) + j / nh : j;
      for (int b = 0; b < 64; b++) begin
        if (b < int'(wOut) && !(w80 && j >= 8)) packed_w[p * int'(wOut) + b] = res[j][b];
      end
    end
  end

  logic          srsV_r;
  logic          srsMem_r;
  logic [1023:0] srsD_r;
  logic          memV_r [STORE_STAGES];
  logic [1023:0] memD_r [STORE_STAGES];
  wire           srsGo = vGo && vReq.op == V_SRS;

  always_ff @(posedge clk) begin
    if (rst) begin
      srsV_r   <= 1'b0;
      srsMem_r <= 1'b0;
      srsD_r   <= '0;
      srsSat_r <= 1'b0;
      vecValid <= 1'b0;
      vecData  <= '0;
    end else begin
      srsV_r   <= srsGo;
      srsMem_r <= vReq.toMem;
      srsD_r   <= packed_w;
      srsSat_r <= srsGo && (satL != 16'h0);
      vecValid <= srsV_r && !srsMem_r;
      vecData  <= srsD_r;
    end
  end

  // store leaves at E3 and reaches memory at E6
  for (genvar k = 0; k < STORE_STAGES; k++) begin : g_mem
    always_ff @(posedge clk) begin
      if (rst) begin
        memV_r[k] <= 1'b0;
        memD_r[k] <= '0;
      end else if (k == 0) begin
        memV_r[k] <= srsV_r && srsMem_r;
        memD_r[k] <= srsD_r;
      end else begin
        memV_r[k] <= memV_r[k-1];
        memD_r[k] <= memD_r[k-1];
      end
    end
  end
  assign memValid = memV_r[STORE_STAGES-1];
  assign memData  = memD_r[STORE_STAGES-1];

  // float multiply: no denormals, results are truncated
  logic [LAT_FMUL-1:0] fv_r;
  logic [7:0]          fn1_r;
  logic [7:0]          fn2_r;
  wire                 fGo = vGo && vReq.op == V_FMUL;

  always_ff @(posedge clk) begin
    if (rst) begin
      fv_r  <= '0;
      fn1_r <= 8'h0;
      fn2_r <= 8'h0;
    end else begin
      fv_r  <= {fv_r[LAT_FMUL-2:0], fGo};
      fn1_r <= vReq.fNeg;
      fn2_r <= fn1_r;
    end
  end
  assign fValid = fv_r[LAT_FMUL-1];

  for (genvar i = 0; i < 8; i++) begin : g_fm
    logic [31:0]       fa_r;
    logic [31:0]       fb_r;
    logic              s2_r;
    logic              z2_r;
    logic signed [9:0] e2_r;
    logic [47:0]       m2_r;
    wire  signed [9:0] en = m2_r[47] ? e2_r + 10'sd1 : e2_r;
    wire        [22:0] mn = m2_r[47] ? m2_r[46:24] : m2_r[45:23];
    wire               sg = s2_r ^ fn2_r[i];
    always_ff @(posedge clk) begin
      fa_r <= pl[32*i +: 32];
      fb_r <= vReq.fOne ? F_ONE : pc[32*i +: 32];
      s2_r <= fa_r[31] ^ fb_r[31];
      z2_r <= fa_r[30:23] == 8'h00 || fb_r[30:23] == 8'h00;
      e2_r <= $signed({2'b00, fa_r[30:23]}) + $signed({2'b00, fb_r[30:23]}) - 10'sd127;
      m2_r <= {1'b1, fa_r[22:0]} * {1'b1, fb_r[22:0]};
      if (rst) fData[32*i +: 32] <= 32'h0;
      else if (z2_r || en <= 10'sh0) fData[32*i +: 32] <= {sg, 31'h0};
      else if (en >= 10'sd255) fData[32*i +: 32] <= {sg, 8'hff, 23'h0};
      else fData[32*i +: 32] <= {sg, en[7:0], mn};
    end
  end
endmodule

// [sim/svmd_chk.sv]
// svmd_chk: port-level latency and answer checks for svmd_top
// assumes one clock domain with synchronous active-high reset
module svmd_chk (
  // clock and reset
  input logic                 clk,
  input logic                 rst,
  // apb
  input logic                 psel,
  input logic                 penable,
  input logic [7:0]           paddr,
  input logic                 pready,
  input logic [31:0]          prdata,
  input logic                 pslverr,
  // scalar
  input svmd_pkg::svmd_sreq_t sReq,
  input logic                 sShortValid,
  input logic [31:0]          sShortData,
  input logic                 sLongValid,
  // vector
  input svmd_pkg::svmd_vreq_t vReq,
  input logic                 vecValid,
  input logic                 memValid,
  input logic                 fValid
);
  timeunit 1ns;
  timeprecision 1ns;
  import svmd_pkg::*;
  wire shortIss = sReq.valid && (sReq.op inside {SC_MAG, SC_LZC, SC_MIN, SC_MAX, SC_FMAG,
                                                SC_FMIN, SC_FMAX, SC_I2F, SC_F2I});
  wire longIss  = sReq.valid && (sReq.op inside {SC_SINCOS, SC_FSQRT, SC_FRSQRT, SC_FRECIP});
  wire magIss   = sReq.valid && sReq.op == SC_MAG;
  wire fmulIss  = vReq.valid && vReq.op == V_FMUL;
  wire srsIss   = vReq.valid && vReq.op == V_SRS;
  wire mapped   = paddr inside {ADDR_MODE, ADDR_SHIFT, ADDR_STAT};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_short_lat; shortIss |=> sShortValid; endproperty
  property p_short_only; sShortValid |-> $past(shortIss); endproperty
  property p_long_lat; longIss |-> ##4 sLongValid; endproperty
  property p_mag_val;
    magIss |=> sShortData == ($past(sReq.a[31]) ? ~$past(sReq.a) + 32'h1 : $past(sReq.a));
  endproperty
  property p_fmul_lat; fmulIss |-> !fValid ##3 fValid; endproperty
  property p_fmul_only; fValid |-> $past(fmulIss, 3); endproperty
  property p_srs_vec; srsIss && !vReq.toMem |-> ##2 vecValid; endproperty
  property p_srs_mem; srsIss && vReq.toMem |-> ##2 !vecValid ##3 memValid; endproperty
  property p_apb_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
  property p_apb_err; pready |-> pslverr == !mapped; endproperty
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  a_short_lat: assert property (p_short_lat) else $error("short result late");
  a_short_only: assert property (p_short_only) else $error("stray short result");
  a_long_lat: assert property (p_long_lat) else $error("long result late");
  a_mag_val: assert property (p_mag_val) else $error("magnitude wrong");
  a_fmul_lat: assert property (p_fmul_lat) else $error("float product late");
  a_fmul_only: assert property (p_fmul_only) else $error("stray float product");
  a_srs_vec: assert property (p_srs_vec) else $error("narrowed result late");
  a_srs_mem: assert property (p_srs_mem) else $error("store not at E6");
  a_apb_wait: assert property (p_apb_wait) else $error("ready not one wait");
  a_apb_err: assert property (p_apb_err) else $error("error flag wrong");
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  c_long: cover property (longIss ##4 sLongValid);
  c_mem: cover property (srsIss && vReq.toMem);
  c_err: cover property (pready && pslverr);
endmodule

bind svmd_top svmd_chk i_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .sReq(sReq), .sShortValid(sShortValid),
  .sShortData(sShortData), .sLongValid(sLongValid), .vReq(vReq), .vecValid(vecValid),
  .memValid(memValid), .fValid(fValid)
);

// [sim/tb_top.sv]
// tb_top: directed self-checking bench for svmd_top
// assumes svmd_pkg encodings and the one-wait-state apb slave of the design
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import svmd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, errv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, sShortData, sLongData, rdv;
  logic pready, pslverr, sShortValid, sLongValid, vecValid, memValid, fValid;
  svmd_sreq_t sReq = '0;
  svmd_vreq_t vReq = '0;
  logic [511:0] srcL = '0, srcR = '0, srcC = '0;
  logic [383:0] cascadeIn = '0;
  logic [767:0] accOut;
  logic [1023:0] vecData, memData;
  logic [255:0] fData;
  int nFail = 0, totalChecks = 0;
  always #25 clk = ~clk;
  svmd_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sReq(sReq), .sShortValid(sShortValid), .sShortData(sShortData),
    .sLongValid(sLongValid), .sLongData(sLongData), .vReq(vReq), .srcL(srcL),
    .srcR(srcR), .srcC(srcC), .cascadeIn(cascadeIn), .accOut(accOut), .vecValid(vecValid),
    .vecData(vecData), .memValid(memValid), .memData(memData), .fValid(fValid),
    .fData(fData));
  task automatic stopTest();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) nFail++;
  endtask
  task automatic sRun(input svmd_sop_t op, input logic [31:0] a, b, input int lat,
                      input logic [31:0] exp, mask);
    @(posedge clk);
    sReq <= '{1'b1, op, a, b};
    @(posedge clk);
    sReq.valid <= 1'b0;
    repeat (lat - 1) @(posedge clk);
    #1;
    check("scalarValid", lat == 1 ? sShortValid : sLongValid, 1'b1);
    check("scalarData", (lat == 1 ? sShortData : sLongData) & mask, exp);
  endtask
  function automatic svmd_vreq_t mk(input svmd_vop_t op);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = op;
  endfunction
  task automatic vRun(input svmd_vreq_t r, input int lat);
    @(posedge clk);
    vReq <= r;
    @(posedge clk);
    vReq <= '0;
    repeat (lat) @(posedge clk);
    #1;
  endtask
  task automatic chkAcc(input logic [47:0] lo, hi);
    for (int i = 0; i < 8; i++) begin
      check("accLow", accOut[i*48 +: 48], lo);
      check("accHigh", accOut[384 + i*48 +: 48], hi);
    end
  endtask
  task automatic testRegs();
    apb(1'b0, ADDR_MODE, 32'h0);
    check("modeReset", rdv, 32'h0);
    apb(1'b0, ADDR_SHIFT, 32'h0);
    check("shiftReset", rdv, 32'h0);
    apb(1'b1, ADDR_MODE, 32'h5b);
    apb(1'b0, ADDR_MODE, 32'h0);
    check("modeBack", rdv, 32'h5b);
    apb(1'b0, 8'h10, 32'h0);
    check("holeErr", {errv, rdv}, {1'b1, 32'h0});
    $display("test regs done");
  endtask
  task automatic testScalar();
    sRun(SC_MAG, 32'hfffffffb, 32'h0, 1, 32'h5, '1);
    sRun(SC_LZC, 32'h00010000, 32'h0, 1, 32'hf, '1);
    sRun(SC_MIN, 32'h3, 32'h9, 1, 32'h3, '1);
    sRun(SC_MAX, 32'h3, 32'h9, 1, 32'h9, '1);
    sRun(SC_FMAG, 32'hc0000000, 32'h0, 1, 32'h40000000, '1);
    sRun(SC_FMIN, 32'h40000000, 32'h40400000, 1, 32'h40000000, '1);
    sRun(SC_FMAX, 32'h40000000, 32'h40400000, 1, 32'h40400000, '1);
    sRun(SC_I2F, 32'hc, 32'h2, 1, 32'h40400000, '1);
    sRun(SC_F2I, 32'h40400000, 32'h2, 1, 32'hc, '1);
    sRun(SC_SINCOS, 32'h00000fff, 32'h0, 4, 32'h0, 32'hffff0000);
    sRun(SC_SINCOS, 32'h40000fff, 32'h0, 4, 32'h0, 32'h0000ffff);
    sRun(SC_FSQRT, 32'h40800000, 32'h0, 4, 32'h40000000, '1);
    sRun(SC_FRSQRT, 32'h40800000, 32'h0, 4, 32'h30000000, 32'hf0000000);
    sRun(SC_FRECIP, 32'h40000000, 32'h0, 4, 32'h30000000, 32'hf0000000);
    $display("test scalar done");
  endtask
  task automatic testMac();
    svmd_vreq_t r;
    srcL <= {32{16'hfffd}};
    r = mk(V_UPS);
    r.upsVec = 1'b1;
    r.upsAmt = 5'd2;
    vRun(r, 0);
    chkAcc(-48'sd12, -48'sd12);
    srcL <= {32{16'h0003}};
    r = mk(V_MAC);
    r.cond = 2'd2;
    vRun(r, 0);
    chkAcc(-48'sd6, -48'sd6);
    r.accSub = 1'b1;
    vRun(r, 0);
    chkAcc(-48'sd12, -48'sd12);
    r.accSub = 1'b0;
    r.preSub = 1'b1;
    r.addSel = 2'd2;
    srcR <= {32{16'h0001}};
    cascadeIn <= {8{48'd100}};
    vRun(r, 0);
    chkAcc(48'd104, 48'd104);
    r.preSub = 1'b0;
    r.addSel = 2'd0;
    r.reduce2 = 1'b1;
    r.dst = 1'b1;
    srcR <= '0;
    vRun(r, 0);
    chkAcc(48'd104, 48'd116);
    r.reduce2 = 1'b0;
    r.cond = 2'd3;
    srcR <= {32{16'h00ff}};
    vRun(r, 0);
    chkAcc(-48'sd412, -48'sd400);
    r.cond = 2'd1;
    srcR <= '0;
    srcC <= {32{16'h0002}};
    vRun(r, 0);
    chkAcc(-48'sd400, -48'sd388);
    $display("test mac done");
  endtask
  task automatic testSrs();
    logic [15:0] expR [2][8] = '{'{16'h1, 16'h2, 16'h2, 16'h1, 16'h2, 16'h1, 16'h2, 16'h1},
      '{16'hfffe, 16'hffff, 16'hffff, 16'hfffe, 16'hfffe, 16'hffff, 16'hfffe, 16'hffff}};
    svmd_vreq_t r;
    apb(1'b1, ADDR_MODE, 32'h10);
    apb(1'b1, ADDR_SHIFT, 32'h82);
    vRun(mk(V_SRS), 1);
    check("srsIlv", vecData[31:0], 32'hff9fff9c);
    r = mk(V_UPS);
    r.upsVec = 1'b1;
    for (int s = 0; s < 2; s++) begin
      srcL <= {32{s ? 16'hfffa : 16'h0006}};
      vRun(r, 0);
      for (int m = 0; m < 8; m++) begin
        apb(1'b1, ADDR_MODE, 32'h10 | m);
        vRun(mk(V_SRS), 1);
        check("srsValid", vecValid, 1'b1);
        check("srsLane0", vecData[15:0], expR[s][m]);
        check("srsLane15", vecData[255:240], expR[s][m]);
        check("srsUnused", vecData[319:256], 64'h0);
      end
    end
    srcL <= {32{16'h03e8}};
    vRun(r, 0);
    apb(1'b1, ADDR_SHIFT, 32'h0);
    apb(1'b1, ADDR_MODE, 32'h48);
    r = mk(V_SRS);
    r.toMem = 1'b1;
    vRun(r, 4);
    check("memValid", memValid, 1'b1);
    check("satLane", memData[7:0], 8'h7f);
    check("mergeDrop", memData[71:64], 8'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("statSet", rdv, 32'h1);
    apb(1'b1, ADDR_STAT, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("statClear", rdv, 32'h0);
    $display("test srs done");
  endtask
  task automatic testFmul();
    svmd_vreq_t r;
    srcL <= {16{32'h40000000}};
    srcC <= {16{32'h40400000}};
    r = mk(V_FMUL);
    r.fNeg = 8'h0f;
    @(posedge clk);
    vReq <= r;
    @(posedge clk);
    r.fOne = 1'b1;
    vReq <= r;
    @(posedge clk);
    vReq <= '0;
    @(posedge clk);
    #1;
    check("fValid", fValid, 1'b1);
    check("fLane0", fData[31:0], 32'hc0c00000);
    check("fLane7", fData[255:224], 32'h40c00000);
    #50;
    check("fValidNext", fValid, 1'b1);
    check("fOneLane0", fData[31:0], 32'hc0000000);
    check("fOneLane7", fData[255:224], 32'h40000000);
    $display("test fmul done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    testRegs();
    testScalar();
    testMac();
    testSrs();
    testFmul();
    stopTest();
  end
  // the tests need well under two thousand cycles
  initial begin
    repeat (6000) @(posedge clk);
    nFail++;
    stopTest();
  end
endmodule
